// ==== src/smbe_defines.svh ====
`ifndef SMBE_DEFINES_SVH
`define SMBE_DEFINES_SVH
// Command byte fields
`define SMBE_CMD_OP 0
`define SMBE_CMD_USA 1
`define SMBE_CMD_NACK 3
`define SMBE_CMD_COND 5
// Command code for serial EEPROM access
`define SMBE_COMMAND_CODE_BYTE_EEPROM 8'h04
// Byte counts after the count field
`define SMBE_CNT_WRITE 8'h05
`define SMBE_CNT_SETUP 8'h04
`define SMBE_CNT_REPLY 8'h05
`define SMBE_REPLY_LAST 3'h5
// Frame byte positions
`define SMBE_POS_COMMAND_CODE_BYTE 4'h0
`define SMBE_POS_COUNT 4'h1
`define SMBE_POS_CMD 4'h2
`define SMBE_POS_ADDR 4'h3
`define SMBE_POS_OFFL 4'h4
`define SMBE_POS_OFFH 4'h5
`define SMBE_POS_DATA 4'h6
// Host register offsets
`define SMBE_REG_CTRL 5'h00
`define SMBE_REG_ADDR 5'h04
`define SMBE_REG_OFFSET 5'h08
`define SMBE_REG_WDATA 5'h0C
`define SMBE_REG_RDATA 5'h10
`define SMBE_REG_STATUS 5'h14
`define SMBE_REG_MASK 5'h18
// Host control and status bits
`define SMBE_CTRL_GO_WRITE 0
`define SMBE_CTRL_GO_READ 1
`define SMBE_CTRL_USA 2
`define SMBE_CTRL_PEC 3
`define SMBE_CTRL_CLR_NACK 4
`define SMBE_CTRL_CLR_COND 5
`define SMBE_CTRL_BUSY 8
`define SMBE_ST_DONE 0
`define SMBE_ST_ERR 1
`define SMBE_RESET_BYTE 8'h00
`endif

// ==== src/smbe_dev.sv ====
// What this block does
// - Command bit 0: zero writes, one reads
// - Bit 1 picks given address, else default
// - Unexpected NACK sets bit 3, write-one clears
// - Misplaced START/STOP sets bit 5, write-one clears
// - Command flags mirror master status flags
// - Host writes zero to bits 7:6
// - Read is setup block write, then block read
// - Write is one block write, PEC optional
// - Bytes: code, count, command, address, offset, data
// - Count gives following bytes, status included
// - Host left-justifies 7-bit address, bit zero clear
// - Offset is high byte over low byte
`include "smbe_defines.svh"
module smbe_dev (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Slave SMBus side
    smbe_if.dev link,
    // Master SMBus side
    output logic mst_start,
    output logic mst_read,
    output logic [6:0] mst_addr,
    output logic [15:0] mst_offset,
    output logic [7:0] mst_wdata,
    input wire logic mst_done,
    input wire logic [7:0] mst_rdata,
    input wire logic mst_nack,
    input wire logic mst_cond_err,
    // Master status register view
    input wire logic [6:0] default_eeprom_bus_address,
    input wire logic sts_clr_nack,
    input wire logic sts_clr_cond,
    output logic nack_error_flag,
    output logic bus_condition_error_flag
);
    smbe_pkg::smbe_dev_state_t state, next_state;
    logic [3:0] idx, next_idx;
    logic [7:0] command_code_byte, next_command_code_byte;
    logic [7:0] byte_count_field, next_byte_count_field;
    logic eeprom_op_select, next_eeprom_op_select;
    logic use_given_bus_address, next_use_given_bus_address;
    logic [7:0] eeprom_bus_address_byte, next_eeprom_bus_address_byte;
    logic [7:0] eeprom_offset_low, next_eeprom_offset_low;
    logic [7:0] eeprom_offset_high, next_eeprom_offset_high;
    logic [7:0] data, next_data;
    logic [7:0] crc, next_crc;
    logic pec_ok, next_pec_ok;
    logic [1:0] clr_req, next_clr_req;
    logic clr_nack, clr_cond;
    logic next_nack, next_cond;
    logic next_mst_start;
    logic next_rd_valid, next_rd_last;
    logic [7:0] next_rd_byte;
    logic [3:0] final_idx;
    logic good;
    logic [7:0] status_byte;

    assign link.busy = (state != smbe_pkg::D_IDLE);

    // Status byte returned to the host mirrors the command layout
    always_comb
    begin
        status_byte = 8'h00;
        status_byte[`SMBE_CMD_OP] = eeprom_op_select;
        status_byte[`SMBE_CMD_USA] = use_given_bus_address;
        status_byte[`SMBE_CMD_NACK] = nack_error_flag;
        status_byte[`SMBE_CMD_COND] = bus_condition_error_flag;
    end

    // Index past the last byte: code, count, counted bytes, then PEC if on
    assign final_idx = byte_count_field[3:0] + (link.pec_en ? 4'h3 : 4'h2);

    // Frame acceptance check, used in the cycle after the last byte
    always_comb
    begin
        good = (command_code_byte == `SMBE_COMMAND_CODE_BYTE_EEPROM)
            && (idx == final_idx)
            && (byte_count_field == (eeprom_op_select ? `SMBE_CNT_SETUP : `SMBE_CNT_WRITE))
            && (!link.pec_en || pec_ok);
    end

    always_comb
    begin
        next_state = state;
        next_idx = idx;
        next_command_code_byte = command_code_byte;
        next_byte_count_field = byte_count_field;
        next_eeprom_op_select = eeprom_op_select;
        next_use_given_bus_address = use_given_bus_address;
        next_eeprom_bus_address_byte = eeprom_bus_address_byte;
        next_eeprom_offset_low = eeprom_offset_low;
        next_eeprom_offset_high = eeprom_offset_high;
        next_data = data;
        next_crc = crc;
        next_pec_ok = pec_ok;
        next_clr_req = clr_req;
        next_mst_start = 1'b0;
        next_rd_valid = 1'b0;
        next_rd_last = 1'b0;
        next_rd_byte = link.rd_byte;
        clr_nack = 1'b0;
        clr_cond = 1'b0;
        case (state)
            smbe_pkg::D_IDLE:
            begin
                if (link.wr_valid)
                begin
                    next_command_code_byte = link.wr_byte;
                    next_crc = smbe_pkg::smbe_crc8(8'h00, link.wr_byte);
                    next_pec_ok = 1'b0;
                    next_idx = 4'h1;
                    // A lone byte is no command
                    next_state = link.wr_last ? smbe_pkg::D_IDLE : smbe_pkg::D_RX;
                end
                else if (link.rd_req)
                begin
                    next_rd_valid = 1'b1;
                    next_rd_byte = `SMBE_CNT_REPLY;
                    next_idx = 4'h1;
                    next_state = smbe_pkg::D_TX;
                end
            end
            smbe_pkg::D_RX:
            begin
                if (link.wr_valid)
                begin
                    case (idx)
                        `SMBE_POS_COUNT: next_byte_count_field = link.wr_byte;
                        `SMBE_POS_CMD:
                        begin
                            // Bits 7:6 are ignored here, the host keeps them zero
                            next_eeprom_op_select = link.wr_byte[`SMBE_CMD_OP];
                            next_use_given_bus_address = link.wr_byte[`SMBE_CMD_USA];
                            next_clr_req[0] = link.wr_byte[`SMBE_CMD_NACK];
                            next_clr_req[1] = link.wr_byte[`SMBE_CMD_COND];
                        end
                        `SMBE_POS_ADDR: next_eeprom_bus_address_byte = link.wr_byte;
                        `SMBE_POS_OFFL: next_eeprom_offset_low = link.wr_byte;
                        `SMBE_POS_OFFH: next_eeprom_offset_high = link.wr_byte;
                        default: ;
                    endcase
                    // Clear requests kept apart, the data byte may carry any bits
                    if (idx == `SMBE_POS_DATA && !eeprom_op_select)
                    begin
                        next_data = link.wr_byte;
                    end
                    next_crc = smbe_pkg::smbe_crc8(crc, link.wr_byte);
                    next_pec_ok = (crc == link.wr_byte);
                    if (idx != 4'hF)
                    begin
                        next_idx = idx + 4'h1;
                    end
                    if (link.wr_last)
                    begin
                        next_state = smbe_pkg::D_DROP;
                    end
                end
            end
            smbe_pkg::D_DROP:
            begin
                // Judge the finished frame; only a whole command starts the master
                if (good)
                begin
                    clr_nack = clr_req[0];
                    clr_cond = clr_req[1];
                    next_mst_start = 1'b1;
                    next_state = smbe_pkg::D_MST;
                end
                else
                begin
                    next_state = smbe_pkg::D_IDLE;
                end
            end
            smbe_pkg::D_MST:
            begin
                if (mst_done)
                begin
                    if (eeprom_op_select)
                    begin
                        next_data = mst_rdata;
                    end
                    next_state = smbe_pkg::D_IDLE;
                end
            end
            smbe_pkg::D_TX:
            begin
                next_rd_valid = 1'b1;
                case (idx[2:0])
                    3'h1: next_rd_byte = status_byte;
                    3'h2: next_rd_byte = eeprom_bus_address_byte;
                    3'h3: next_rd_byte = eeprom_offset_low;
                    3'h4: next_rd_byte = eeprom_offset_high;
                    default: next_rd_byte = data;
                endcase
                next_rd_last = (idx[2:0] == `SMBE_REPLY_LAST);
                next_idx = idx + 4'h1;
                if (idx[2:0] == `SMBE_REPLY_LAST)
                begin
                    next_state = smbe_pkg::D_IDLE;
                end
            end
            default: next_state = smbe_pkg::D_IDLE;
        endcase
    end

    // Sticky flags shared with the master status register; a set wins
    always_comb
    begin
        next_nack = mst_nack || (nack_error_flag && !clr_nack && !sts_clr_nack);
        next_cond = mst_cond_err || (bus_condition_error_flag && !clr_cond && !sts_clr_cond);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state <= smbe_pkg::D_IDLE;
            idx <= 4'h0;
            command_code_byte <= `SMBE_RESET_BYTE;
            byte_count_field <= `SMBE_RESET_BYTE;
            eeprom_op_select <= 1'b0;
            use_given_bus_address <= 1'b0;
            eeprom_bus_address_byte <= `SMBE_RESET_BYTE;
            eeprom_offset_low <= `SMBE_RESET_BYTE;
            eeprom_offset_high <= `SMBE_RESET_BYTE;
            data <= `SMBE_RESET_BYTE;
            crc <= 8'h00;
            pec_ok <= 1'b0;
            clr_req <= 2'h0;
            mst_start <= 1'b0;
            nack_error_flag <= 1'b0;
            bus_condition_error_flag <= 1'b0;
            link.rd_valid <= 1'b0;
            link.rd_last <= 1'b0;
            link.rd_byte <= 8'h00;
        end
        else
        begin
            state <= next_state;
            idx <= next_idx;
            command_code_byte <= next_command_code_byte;
            byte_count_field <= next_byte_count_field;
            eeprom_op_select <= next_eeprom_op_select;
            use_given_bus_address <= next_use_given_bus_address;
            eeprom_bus_address_byte <= next_eeprom_bus_address_byte;
            eeprom_offset_low <= next_eeprom_offset_low;
            eeprom_offset_high <= next_eeprom_offset_high;
            data <= next_data;
            crc <= next_crc;
            pec_ok <= next_pec_ok;
            clr_req <= next_clr_req;
            mst_start <= next_mst_start;
            nack_error_flag <= next_nack;
            bus_condition_error_flag <= next_cond;
            link.rd_valid <= next_rd_valid;
            link.rd_last <= next_rd_last;
            link.rd_byte <= next_rd_byte;
        end
    end

    // Held stable from the start pulse to done
    assign mst_read = eeprom_op_select;
    assign mst_addr = use_given_bus_address ? eeprom_bus_address_byte[7:1]
                                            : default_eeprom_bus_address;
    assign mst_offset = {eeprom_offset_high, eeprom_offset_low};
    assign mst_wdata = data;
endmodule : smbe_dev

// ==== src/smbe_host.sv ====
`include "smbe_defines.svh"
module smbe_host (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [4:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    // Link to the device
    smbe_if.host link
);
    smbe_pkg::smbe_host_state_t state, next_state;
    logic [3:0] idx, next_idx;
    logic op_read, next_op_read;
    logic [5:0] ctrl, next_ctrl;
    logic [6:0] ee_addr, next_ee_addr;
    logic [15:0] offset, next_offset;
    logic [7:0] wdata, next_wdata;
    logic [15:0] rdata, next_rdata;
    logic [1:0] status, next_status, mask, next_mask;
    logic [7:0] crc, next_crc;
    logic [31:0] next_reg_rdata;
    logic [7:0] cmd, tx_byte;
    logic [3:0] last_idx;
    logic ev_done, ev_err;
    logic go;

    // Reserved bits 7:6, 4 and 2 go out as zero
    always_comb
    begin
        cmd = 8'h00;
        cmd[`SMBE_CMD_OP] = op_read;
        cmd[`SMBE_CMD_USA] = ctrl[`SMBE_CTRL_USA];
        cmd[`SMBE_CMD_NACK] = ctrl[`SMBE_CTRL_CLR_NACK];
        cmd[`SMBE_CMD_COND] = ctrl[`SMBE_CTRL_CLR_COND];
    end

    always_comb
    begin
        case (idx)
            `SMBE_POS_COMMAND_CODE_BYTE: tx_byte = `SMBE_COMMAND_CODE_BYTE_EEPROM;
            `SMBE_POS_COUNT: tx_byte = op_read ? `SMBE_CNT_SETUP : `SMBE_CNT_WRITE;
            `SMBE_POS_CMD: tx_byte = cmd;
            `SMBE_POS_ADDR: tx_byte = {ee_addr, 1'b0};
            `SMBE_POS_OFFL: tx_byte = offset[7:0];
            `SMBE_POS_OFFH: tx_byte = offset[15:8];
            default: tx_byte = (idx == `SMBE_POS_DATA && !op_read) ? wdata : crc;
        endcase
    end

    assign last_idx = (op_read ? 4'h5 : 4'h6) + (ctrl[`SMBE_CTRL_PEC] ? 4'h1 : 4'h0);
    assign go = reg_wr && reg_addr == `SMBE_REG_CTRL && state == smbe_pkg::H_IDLE
        && (reg_wdata[`SMBE_CTRL_GO_WRITE] || reg_wdata[`SMBE_CTRL_GO_READ]);

    always_comb
    begin
        next_state = state;
        next_idx = idx;
        next_op_read = op_read;
        next_crc = crc;
        next_rdata = rdata;
        ev_done = 1'b0;
        ev_err = 1'b0;
        link.wr_valid = 1'b0;
        link.wr_last = 1'b0;
        link.wr_byte = tx_byte;
        link.rd_req = 1'b0;
        case (state)
            smbe_pkg::H_IDLE:
            begin
                if (go)
                begin
                    next_op_read = reg_wdata[`SMBE_CTRL_GO_READ];
                    next_idx = 4'h0;
                    next_crc = 8'h00;
                    next_state = smbe_pkg::H_SEND;
                end
            end
            smbe_pkg::H_SEND:
            begin
                link.wr_valid = 1'b1;
                link.wr_last = (idx == last_idx);
                next_crc = smbe_pkg::smbe_crc8(crc, tx_byte);
                next_idx = idx + 4'h1;
                if (idx == last_idx)
                begin
                    next_state = smbe_pkg::H_WAIT;
                end
            end
            smbe_pkg::H_WAIT:
            begin
                if (!link.busy)
                begin
                    next_state = op_read ? smbe_pkg::H_RDREQ : smbe_pkg::H_IDLE;
                    ev_done = !op_read;
                end
            end
            smbe_pkg::H_RDREQ:
            begin
                link.rd_req = 1'b1;
                next_idx = 4'h0;
                next_state = smbe_pkg::H_RX;
            end
            smbe_pkg::H_RX:
            begin
                if (link.rd_valid)
                begin
                    if (idx == 4'h1)
                    begin
                        next_rdata[15:8] = link.rd_byte;
                    end
                    next_idx = idx + 4'h1;
                    if (link.rd_last)
                    begin
                        next_rdata[7:0] = link.rd_byte;
                        ev_done = 1'b1;
                        ev_err = rdata[8 + `SMBE_CMD_NACK] || rdata[8 + `SMBE_CMD_COND];
                        next_state = smbe_pkg::H_IDLE;
                    end
                end
            end
            default: next_state = smbe_pkg::H_IDLE;
        endcase
    end

    always_comb
    begin
        next_ctrl = ctrl;
        next_ee_addr = ee_addr;
        next_offset = offset;
        next_wdata = wdata;
        next_mask = mask;
        next_status = status | {ev_err, ev_done};
        if (reg_wr)
        begin
            case (reg_addr)
                `SMBE_REG_CTRL:
                    if (state == smbe_pkg::H_IDLE)
                    begin
                        next_ctrl = reg_wdata[5:0];
                    end
                `SMBE_REG_ADDR: next_ee_addr = reg_wdata[6:0];
                `SMBE_REG_OFFSET: next_offset = reg_wdata[15:0];
                `SMBE_REG_WDATA: next_wdata = reg_wdata[7:0];
                `SMBE_REG_MASK: next_mask = reg_wdata[1:0];
                // Write one clears; a new event in the same cycle stays set
                `SMBE_REG_STATUS: next_status = (status & ~reg_wdata[1:0]) | {ev_err, ev_done};
                default: ;
            endcase
        end
        next_reg_rdata = 32'h0000_0000;
        if (reg_rd)
        begin
            case (reg_addr)
                `SMBE_REG_CTRL: next_reg_rdata = {23'h0, state != smbe_pkg::H_IDLE, 2'h0, ctrl};
                `SMBE_REG_ADDR: next_reg_rdata = {25'h0, ee_addr};
                `SMBE_REG_OFFSET: next_reg_rdata = {16'h0, offset};
                `SMBE_REG_WDATA: next_reg_rdata = {24'h0, wdata};
                `SMBE_REG_RDATA: next_reg_rdata = {16'h0, rdata};
                `SMBE_REG_STATUS: next_reg_rdata = {30'h0, status};
                `SMBE_REG_MASK: next_reg_rdata = {30'h0, mask};
                default: next_reg_rdata = 32'h0000_0000;
            endcase
        end
    end

    assign link.pec_en = ctrl[`SMBE_CTRL_PEC];
    assign irq = |(status & mask);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state <= smbe_pkg::H_IDLE;
            idx <= 4'h0;
            op_read <= 1'b0;
            crc <= 8'h00;
            rdata <= 16'h0000;
            ctrl <= 6'h00;
            ee_addr <= 7'h00;
            offset <= 16'h0000;
            wdata <= 8'h00;
            status <= 2'h0;
            mask <= 2'h0;
            reg_rdata <= 32'h0000_0000;
        end
        else
        begin
            state <= next_state;
            idx <= next_idx;
            op_read <= next_op_read;
            crc <= next_crc;
            rdata <= next_rdata;
            ctrl <= next_ctrl;
            ee_addr <= next_ee_addr;
            offset <= next_offset;
            wdata <= next_wdata;
            status <= next_status;
            mask <= next_mask;
            reg_rdata <= next_reg_rdata;
        end
    end
endmodule : smbe_host

// ==== src/smbe_if.sv ====
interface smbe_if;
    logic wr_valid;
    logic [7:0] wr_byte;
    logic wr_last;
    logic pec_en;
    logic rd_req;
    logic busy;
    logic rd_valid;
    logic [7:0] rd_byte;
    logic rd_last;

    modport dev (
        input wr_valid, wr_byte, wr_last, pec_en, rd_req,
        output busy, rd_valid, rd_byte, rd_last
    );
    modport host (
        output wr_valid, wr_byte, wr_last, pec_en, rd_req,
        input busy, rd_valid, rd_byte, rd_last
    );
endinterface : smbe_if

// ==== src/smbe_pkg.sv ====
package smbe_pkg;
    typedef enum logic [2:0] {D_IDLE, D_RX, D_DROP, D_MST, D_TX} smbe_dev_state_t;
    typedef enum logic [2:0] {H_IDLE, H_SEND, H_WAIT, H_RDREQ, H_RX} smbe_host_state_t;

    // One byte step of the SMBus packet error code, x^8+x^2+x+1
    function automatic logic [7:0] smbe_crc8(input logic [7:0] crc, input logic [7:0] b);
        logic [7:0] c;
        c = crc ^ b;
        for (int i = 0; i < 8; i++)
        begin
            c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
        end
        return c;
    endfunction : smbe_crc8
endpackage : smbe_pkg

// ==== testbench/smbe_checker.sv ====
module smbe_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link
    input wire logic wr_valid,
    input wire logic wr_last,
    input wire logic rd_req,
    input wire logic busy,
    input wire logic rd_valid,
    input wire logic [7:0] rd_byte,
    input wire logic rd_last,
    // Master side and flags
    input wire logic mst_start,
    input wire logic mst_done,
    input wire logic mst_nack,
    input wire logic mst_cond_err,
    input wire logic sts_clr_nack,
    input wire logic nack_error_flag,
    input wire logic bus_condition_error_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    frame_busy_a: assert property (wr_valid && wr_last |=> busy)
        else $error("busy missing after last byte");
    start_late_a: assert property (mst_start |-> busy && $past(busy) && !wr_valid)
        else $error("master access before frame end");
    start_pulse_a: assert property (mst_start |=> !mst_start)
        else $error("master start longer than one cycle");
    done_idle_a: assert property (mst_done && busy |=> !busy)
        else $error("busy held after master done");
    reply_len_a: assert property (rd_req && !busy |=> rd_valid [*6] ##1 !rd_valid)
        else $error("reply not six bytes");
    reply_count_a: assert property (
        rd_req && !busy |=> rd_byte == 8'h05 && !rd_last ##5 rd_last)
        else $error("reply count or last mark wrong");
    nack_set_a: assert property (mst_nack |=> nack_error_flag)
        else $error("nack flag not set");
    cond_set_a: assert property (mst_cond_err |=> bus_condition_error_flag)
        else $error("bus condition flag not set");
    nack_clear_a: assert property (
        $fell(nack_error_flag) |-> $past(sts_clr_nack) || $past(busy))
        else $error("nack flag cleared without cause");
endmodule : smbe_checker

// ==== testbench/test_smbus_slave_eeprom_command.sv ====
`include "smbe_defines.svh"
module test_smbus_slave_eeprom_command;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic irq, mst_start, mst_read, nack_error_flag, bus_condition_error_flag;
    logic [6:0] mst_addr;
    logic [15:0] mst_offset;
    logic [7:0] mst_wdata;
    logic mst_done = 1'b0;
    logic mst_nack = 1'b0;
    logic mst_cond_err = 1'b0;
    logic sts_clr_nack = 1'b0;
    logic sts_clr_cond = 1'b0;
    logic [7:0] mst_rdata = 8'hC3;
    logic [6:0] dflt_addr = 7'h50;
    logic inj_nack = 1'b0;
    logic inj_cond = 1'b0;
    logic e_read = 1'b0;
    logic [6:0] e_addr = 7'h50;
    logic [63:0] fr = 64'h0;
    logic [31:0] v;
    int errors = 0;
    int n_tests = 0;
    int nb = 0;
    int ns = 0;
    int pend = 0;
    smbe_if link_if ();
    always #4 clk = ~clk;
    smbe_host i_smbe_host (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .link(link_if));
    smbe_dev i_smbe_dev (.clk(clk), .rst_n(rst_n), .link(link_if), .mst_start(mst_start),
        .mst_read(mst_read), .mst_addr(mst_addr), .mst_offset(mst_offset),
        .mst_wdata(mst_wdata), .mst_done(mst_done), .mst_rdata(mst_rdata),
        .mst_nack(mst_nack), .mst_cond_err(mst_cond_err),
        .default_eeprom_bus_address(dflt_addr), .sts_clr_nack(sts_clr_nack),
        .sts_clr_cond(sts_clr_cond), .nack_error_flag(nack_error_flag),
        .bus_condition_error_flag(bus_condition_error_flag));
    smbe_checker i_smbe_checker (.clk(clk), .rst_n(rst_n), .wr_valid(link_if.wr_valid),
        .wr_last(link_if.wr_last), .rd_req(link_if.rd_req), .busy(link_if.busy),
        .rd_valid(link_if.rd_valid), .rd_byte(link_if.rd_byte), .rd_last(link_if.rd_last),
        .mst_start(mst_start), .mst_done(mst_done), .mst_nack(mst_nack),
        .mst_cond_err(mst_cond_err), .sts_clr_nack(sts_clr_nack),
        .nack_error_flag(nack_error_flag),
        .bus_condition_error_flag(bus_condition_error_flag));
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        if (errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    // Polls done so a dropped frame cannot hang the run
    task automatic op(input logic [31:0] c);
        nb = 0;
        wr(`SMBE_REG_CTRL, c);
        rd(`SMBE_REG_CTRL);
        chk(v[8], 1'b1);
        // Control readback holds the go bits, so poll status afresh
        v = 32'h0;
        for (int i = 0; i < 60 && v[0] !== 1'b1; i++)
            rd(`SMBE_REG_STATUS);
        chk(v[0], 1'b1);
    endtask : op
    // Wire capture of every byte the host sends
    always @(posedge clk)
        if (link_if.wr_valid === 1'b1)
        begin
            fr = {fr[55:0], link_if.wr_byte};
            nb++;
        end
    // EEPROM side answers three cycles after each start
    always @(posedge clk)
    begin
        mst_done <= 1'b0;
        mst_nack <= 1'b0;
        mst_cond_err <= 1'b0;
        if (mst_start === 1'b1)
        begin
            ns++;
            chk({mst_read, mst_addr, mst_offset}, {e_read, e_addr, 16'h1234});
            if (!e_read)
                chk(mst_wdata, 8'hA5);
            pend = 3;
        end
        else if (pend == 1)
        begin
            mst_done <= 1'b1;
            mst_nack <= inj_nack;
            mst_cond_err <= inj_cond;
            pend = 0;
        end
        else if (pend > 1)
            pend--;
    end
    initial
    begin
        repeat (3000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd(`SMBE_REG_STATUS);
        chk({v, nack_error_flag, bus_condition_error_flag}, 34'h0);
        wr(5'h1C, 32'hFFFFFFFF);
        rd(5'h1C);
        chk(v, 32'h0);
        wr(`SMBE_REG_ADDR, 32'h2A);
        wr(`SMBE_REG_OFFSET, 32'h1234);
        wr(`SMBE_REG_WDATA, 32'hA5);
        wr(`SMBE_REG_MASK, 32'h1);
        op(32'h1);
        chk({nb[7:0], fr[55:0]}, 64'h0704_0500_5434_12A5);
        chk(irq, 1'b1);
        wr(`SMBE_REG_STATUS, 32'h1);
        rd(`SMBE_REG_STATUS);
        chk({v, irq}, 33'h0);
        e_read = 1'b1;
        e_addr = 7'h2A;
        inj_nack = 1'b1;
        op(32'h6);
        chk({nb[7:0], fr[47:0]}, 64'h0006_0404_0354_3412);
        inj_nack = 1'b0;
        rd(`SMBE_REG_RDATA);
        chk({v, nack_error_flag}, {32'h00000BC3, 1'b1});
        rd(`SMBE_REG_STATUS);
        chk(v, 32'h3);
        @(posedge clk);
        sts_clr_nack <= 1'b1;
        @(posedge clk);
        sts_clr_nack <= 1'b0;
        @(negedge clk);
        chk(nack_error_flag, 1'b0);
        wr(`SMBE_REG_STATUS, 32'h3);
        wr(`SMBE_REG_MASK, 32'h0);
        e_read = 1'b0;
        e_addr = 7'h50;
        inj_cond = 1'b1;
        op(32'h9);
        chk({nb[7:0], fr[63:8]}, 64'h0804_0500_5434_12A5);
        chk({irq, bus_condition_error_flag, ns[7:0]}, {2'b01, 8'h03});
        wr(`SMBE_REG_MASK, 32'h1);
        rd(`SMBE_REG_MASK);
        chk(irq, 1'b1);
        wr(`SMBE_REG_STATUS, 32'h3);
        inj_cond = 1'b0;
        // Data byte has bit 5 set and must not clear the flag
        op(32'h1);
        chk(bus_condition_error_flag, 1'b1);
        @(posedge clk);
        sts_clr_cond <= 1'b1;
        @(posedge clk);
        sts_clr_cond <= 1'b0;
        @(negedge clk);
        chk(bus_condition_error_flag, 1'b0);
        inj_cond = 1'b1;
        wr(`SMBE_REG_STATUS, 32'h3);
        op(32'h1);
        inj_cond = 1'b0;
        chk(bus_condition_error_flag, 1'b1);
        wr(`SMBE_REG_STATUS, 32'h3);
        // Clear request rides in the command byte itself
        op(32'h21);
        chk({nb[7:0], fr[55:0]}, 64'h0704_0520_5434_12A5);
        chk(bus_condition_error_flag, 1'b0);
        tally_and_finish();
    end
endmodule : test_smbus_slave_eeprom_command
